// >>> rtl/hbc_ctrl.v
// Purpose: Host bus control signals: select, hold-off, address strobe.
// Assumes: Host pins are asynchronous; mode select is static.
// Notes:   Hold-off pin is output, value and output enable.
`timescale 1ns/1ps
`default_nettype none
`include "hbc_defines.vh"
module hbc_ctrl (
	// Clock and reset
	input  wire       clk_in,
	input  wire       rst_in,
	// Mode
	input  wire [1:0] mode_in,
	// Host pins
	input  wire       cs_n_in,
	input  wire       as_n_in,
	input  wire       rd_n_in,
	input  wire       wr_n_in,
	// Hold-off pin
	output reg        hold_out,
	output reg        hold_oe_out,
	// Core side
	output reg        data_oe_out,
	output reg        rd_stb_out,
	output reg        wr_stb_out
);
	// ==================================================================
	// One-hot transfer states.
	localparam [3:0] ST_IDLE = `HBC_ST_IDLE;
	localparam [3:0] ST_BUSY = `HBC_ST_BUSY;
	localparam [3:0] ST_DONE = `HBC_ST_DONE;
	localparam [3:0] ST_HOLD = `HBC_ST_HOLD;
	// ==================================================================
	// Helpers.
	// True when a synchronised level has just gone from high to low.
	function fell_f;
		input cur;
		input prev;
		begin
			fell_f = ~cur & prev;
		end
	endfunction
	// True when a synchronised level has just gone from low to high.
	function rose_f;
		input cur;
		input prev;
		begin
			rose_f = cur & ~prev;
		end
	endfunction
	// True in the states in which the hold-off pin is driven.
	function hold_drive_f;
		input [3:0] st;
		begin
			hold_drive_f = (st == ST_BUSY) | (st == ST_DONE);
		end
	endfunction
	// Level shown on the hold-off pin while it is driven.
	function hold_level_f;
		input       ack;
		input [3:0] st;
		begin
			if (ack) begin
				hold_level_f = (st != ST_DONE);
			end else begin
				hold_level_f = (st != ST_BUSY);
			end
		end
	endfunction
	wire       cs_n_s;
	wire       as_n_s;
	wire       rd_n_s;
	wire       wr_n_s;
	reg        rd_n_d_reg;
	reg        wr_n_d_reg;
	reg  [3:0] state_reg;
	reg  [3:0] state_next;
	reg  [3:0] cnt_reg;
	reg  [3:0] cnt_next;
	reg        is_rd_reg;
	reg        is_rd_next;
	reg        go;
	reg        go_rd;
	reg        sel;
	reg        act;
	wire       gen_mode;
	wire       ack_mode;
	// ==================================================================
	// Mode decode.
	assign gen_mode = (mode_in == `HBC_MODE_GENERIC);
	assign ack_mode = (mode_in == `HBC_MODE_STROBE);
	// ==================================================================
	// Pin synchronisers.
	hbc_sync #(.RST_VAL(1'b1)) u_cs (.clk_in(clk_in), .rst_in(rst_in),
		.d_in(cs_n_in), .q_out(cs_n_s));
	hbc_sync #(.RST_VAL(1'b1)) u_as (.clk_in(clk_in), .rst_in(rst_in),
		.d_in(as_n_in), .q_out(as_n_s));
	hbc_sync #(.RST_VAL(1'b1)) u_rd (.clk_in(clk_in), .rst_in(rst_in),
		.d_in(rd_n_in), .q_out(rd_n_s));
	hbc_sync #(.RST_VAL(1'b1)) u_wr (.clk_in(clk_in), .rst_in(rst_in),
		.d_in(wr_n_in), .q_out(wr_n_s));
	// ==================================================================
	// Start detection per mode.
	always @* begin
		go    = 1'b0;
		go_rd = 1'b0;
		act   = 1'b0;
		sel   = ~cs_n_s;
		case (mode_in)
		`HBC_MODE_GENERIC: begin
			act = ~rd_n_s;
			if (fell_f(rd_n_s, rd_n_d_reg)) begin
				go    = sel;
				go_rd = 1'b1;
			end
			if (rose_f(wr_n_s, wr_n_d_reg)) begin
				go    = sel;
				go_rd = 1'b0;
			end
		end
		`HBC_MODE_ECLK: begin
			// The enable clock is active high: its rise starts a transfer.
			act   = rd_n_s & wr_n_s;
			go    = sel & rose_f(rd_n_s, rd_n_d_reg);
			go_rd = wr_n_s;
		end
		`HBC_MODE_STROBE: begin
			sel   = ~cs_n_s & ~as_n_s;
			act   = ~rd_n_s & wr_n_s;
			// The data strobe is active low: its fall starts a transfer.
			go    = sel & fell_f(rd_n_s, rd_n_d_reg);
			go_rd = wr_n_s;
		end
		default: begin
			sel = 1'b0;
		end
		endcase
	end
	// ==================================================================
	// Transfer state machine.
	always @* begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		is_rd_next = is_rd_reg;
		case (state_reg)
		ST_IDLE: begin
			if (go) begin
				state_next = ST_BUSY;
				cnt_next   = `HBC_BUSY_CYCLES;
				is_rd_next = go_rd;
			end
		end
		ST_BUSY: begin
			if (cnt_reg == `HBC_CNT_ONE) begin
				state_next = ST_DONE;
				cnt_next   = `HBC_DONE_CYCLES;
			end else begin
				cnt_next = cnt_reg - `HBC_CNT_ONE;
			end
		end
		ST_DONE: begin
			if (cnt_reg == `HBC_CNT_ONE) begin
				state_next = ST_HOLD;
				cnt_next   = `HBC_CNT_ZERO;
			end else begin
				cnt_next = cnt_reg - `HBC_CNT_ONE;
			end
		end
		ST_HOLD: begin
			if (~sel | ~act) begin
				state_next = ST_IDLE;
			end
		end
		default: begin
			state_next = ST_IDLE;
			cnt_next   = `HBC_CNT_ZERO;
		end
		endcase
		if (~sel) begin
			state_next = ST_IDLE;
			cnt_next   = `HBC_CNT_ZERO;
		end
	end
	// ==================================================================
	// Registers and outputs.
	always @(posedge clk_in) begin
		if (rst_in) begin
			state_reg   <= ST_IDLE;
			cnt_reg     <= `HBC_CNT_ZERO;
			is_rd_reg   <= 1'b0;
			rd_n_d_reg  <= 1'b1;
			wr_n_d_reg  <= 1'b1;
			hold_out    <= 1'b1;
			hold_oe_out <= 1'b0;
			data_oe_out <= 1'b0;
			rd_stb_out  <= 1'b0;
			wr_stb_out  <= 1'b0;
		end else begin
			state_reg   <= state_next;
			cnt_reg     <= cnt_next;
			is_rd_reg   <= is_rd_next;
			rd_n_d_reg  <= rd_n_s;
			wr_n_d_reg  <= wr_n_s;
			rd_stb_out  <= go & go_rd;
			wr_stb_out  <= go & ~go_rd;
			data_oe_out <= sel & act & (mode_in == `HBC_MODE_GENERIC ?
				1'b1 : is_rd_next);
			if (gen_mode | ack_mode) begin
				// Generic mode waits low, strobe mode waits high.
				hold_out    <= hold_level_f(ack_mode, state_next);
				hold_oe_out <= hold_drive_f(state_next);
			end else begin
				hold_out    <= 1'b1;
				hold_oe_out <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// >>> rtl/hbc_defines.vh
// Purpose: Constants for the host bus control block.
// Assumes: Included by the control module by its bare name; the synchroniser does not include it.
// Notes:   Mode codes and timing counts live here.
`ifndef HBC_DEFINES_VH
`define HBC_DEFINES_VH
// ==========================================================================
// Bus mode select codes.
`define HBC_MODE_GENERIC 2'h0
`define HBC_MODE_ECLK    2'h1
`define HBC_MODE_STROBE  2'h2
// ==========================================================================
// Transfer timing in clock cycles.
`define HBC_BUSY_CYCLES  4'h3
`define HBC_DONE_CYCLES  4'h1
`define HBC_CNT_ZERO     4'h0
`define HBC_CNT_ONE      4'h1
// ==========================================================================
// States, one-hot.
`define HBC_ST_IDLE      4'h1
`define HBC_ST_BUSY      4'h2
`define HBC_ST_DONE      4'h4
`define HBC_ST_HOLD      4'h8
`endif

// >>> rtl/hbc_sync.v
// Purpose: Three-stage synchroniser with agreement filter for pin inputs.
// Assumes: Single clock clk_in; synchronous active-high reset.
// Notes:   Output changes only when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module hbc_sync #(
	parameter [0:0] RST_VAL = 1'b1
) (
	// Clock and reset
	input  wire clk_in,
	input  wire rst_in,
	// Data
	input  wire d_in,
	output reg  q_out
);
	reg s1_reg;
	reg s2_reg;
	reg s3_reg;
	// ==================================================================
	// Stages and filter.
	always @(posedge clk_in) begin
		if (rst_in) begin
			s1_reg <= RST_VAL;
			s2_reg <= RST_VAL;
			s3_reg <= RST_VAL;
			q_out  <= RST_VAL;
		end else begin
			s1_reg <= d_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg) begin
				q_out <= s3_reg;
			end
		end
	end
endmodule
`default_nettype wire

// >>> tb/hbc_ctrl_monitor.sv
// Purpose: Port checks for hbc_ctrl.
// Assumes: Bound from the bench; one clock.
// Notes:   Hold-off timing follows the mode.
`timescale 1ns/1ps
`default_nettype none
module hbc_ctrl_monitor (
	input wire       clk_in,
	input wire       rst_in,
	input wire [1:0] mode_in,
	input wire       cs_n_in,
	input wire       as_n_in,
	input wire       hold_out,
	input wire       hold_oe_out,
	input wire       data_oe_out,
	input wire       rd_stb_out,
	input wire       wr_stb_out
);
	// ======
	// Checks.
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	wire stb = rd_stb_out | wr_stb_out;
	reg  rst_q;
	always @(posedge clk_in) begin
		rst_q <= rst_in;
	end
	sequence s_gen;
		(hold_oe_out && !hold_out)[*3] ##1 hold_oe_out && hold_out
		##1 !hold_oe_out;
	endsequence
	sequence s_ack;
		(hold_oe_out && hold_out)[*3] ##1 hold_oe_out && !hold_out
		##1 !hold_oe_out;
	endsequence
	property p_gen; mode_in == 2'h0 && stb |-> s_gen; endproperty
	property p_ack; mode_in == 2'h2 && stb |-> s_ack; endproperty
	property p_eclk; mode_in == 2'h1 |-> !hold_oe_out; endproperty
	property p_desel; cs_n_in[*6] |-> !hold_oe_out && !stb; endproperty
	property p_as; (mode_in == 2'h2 && as_n_in)[*6] |-> !stb; endproperty
	property p_pulse; stb |=> !stb; endproperty
	property p_dir; !(rd_stb_out && wr_stb_out); endproperty
	property p_none; mode_in == 2'h3 |-> !stb && !hold_oe_out; endproperty
	property p_rst;
		!rst_in && rst_q |-> !hold_oe_out && hold_out && !stb
		&& !data_oe_out ##1 !hold_oe_out;
	endproperty
	a_gen: assert property (p_gen) else $error("gen hold");
	a_ack: assert property (p_ack) else $error("ack hold");
	a_eclk: assert property (p_eclk) else $error("eclk hold");
	a_desel: assert property (p_desel) else $error("desel");
	a_as: assert property (p_as) else $error("as high");
	a_pulse: assert property (p_pulse) else $error("pulse");
	a_dir: assert property (p_dir) else $error("dir");
	a_none: assert property (p_none) else $error("no mode");
	a_rst: assert property (p_rst) else $error("reset");
	property p_doe; cs_n_in[*6] |-> !data_oe_out; endproperty
	a_doe: assert property (p_doe) else $error("desel drive");
endmodule
`default_nettype wire

// >>> tb/hbc_host.sv
// Purpose: Host model making one bus frame per go pulse.
// Assumes: Mode is static during a frame.
// Notes:   Strobe active cycles 2 to 11, frame ends at 24.
`timescale 1ns/1ps
`default_nettype none
module hbc_host (
	input  wire logic       clk_in,
	input  wire logic       go_in,
	input  wire logic       rd_in,
	input  wire logic [1:0] mode_in,
	output logic            cs_n_out = 1'b1,
	output logic            as_n_out = 1'b1,
	output logic            rd_n_out = 1'b1,
	output logic            wr_n_out = 1'b1
);
	logic [4:0] cnt = 5'h00;
	wire        ph = cnt >= 5'h02 && cnt <= 5'h0B;
	wire        run = (go_in || cnt != 5'h00) && cnt != 5'h18;
	// ======
	// Pins.
	always @(posedge clk_in) begin
		cnt <= run ? cnt + 5'h01 : 5'h00;
		cs_n_out <= cnt == 5'h00;
		as_n_out <= !(mode_in == 2'h2 && cnt != 5'h00);
		rd_n_out <= mode_in == 2'h1 ? ph : !(ph && (rd_in || mode_in != 2'h0));
		wr_n_out <= mode_in == 2'h0 ? !(!rd_in && ph) : rd_in;
	end
endmodule
`default_nettype wire

// >>> tb/host_bus_control_signals_bench.sv
// Purpose: Bench for hbc_ctrl in every bus mode.
// Assumes: Host model makes the pin frames.
// Notes:   Counts strobes and hold-off cycles.
`timescale 1ns/1ps
`default_nettype none
module host_bus_control_signals_bench;
	logic       clk_in = 1'b0;
	logic       rst_in = 1'b1;
	logic       go = 1'b0;
	logic       rd = 1'b0;
	logic [1:0] mode = 2'h0;
	wire        cs_n, as_n, rd_n, wr_n, hold, hold_oe, data_oe, rd_stb, wr_stb;
	int         n_fail = 0;
	int         n_compared = 0;
	int         cyc = 0;
	logic [7:0] nr, nw, noe, nwt, ndo, nst;
	hbc_host u_host (.clk_in(clk_in), .go_in(go), .rd_in(rd), .mode_in(mode),
		.cs_n_out(cs_n), .as_n_out(as_n), .rd_n_out(rd_n), .wr_n_out(wr_n));
	hbc_ctrl u_dut (.clk_in(clk_in), .rst_in(rst_in), .mode_in(mode),
		.cs_n_in(cs_n), .as_n_in(as_n), .rd_n_in(rd_n), .wr_n_in(wr_n),
		.hold_out(hold), .hold_oe_out(hold_oe), .data_oe_out(data_oe),
		.rd_stb_out(rd_stb), .wr_stb_out(wr_stb));
	// ======
	// Tasks.
	task check(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task xfer(input logic [1:0] m, input logic r);
		logic [7:0] k;
		{nr, nw, noe, nwt, ndo, nst} = 48'h0;
		@(posedge clk_in);
		mode <= m;
		rd <= r;
		go <= 1'b1;
		@(posedge clk_in);
		go <= 1'b0;
		for (k = 8'h01; k <= 8'h1E; k++) begin
			@(posedge clk_in);
			#1;
			if ((rd_stb || wr_stb) && nst == 8'h00) begin
				nst = k;
			end
			ndo = ndo + {7'h00, data_oe};
			nr = nr + {7'h00, rd_stb};
			nw = nw + {7'h00, wr_stb};
			noe = noe + {7'h00, hold_oe};
			nwt = nwt + {7'h00, hold_oe && (hold == (m == 2'h2))};
		end
	endtask
	task exp4(input logic [7:0] er, ew, eo, et);
		check(nr, er);
		check(nw, ew);
		check(noe, eo);
		check(nwt, et);
	endtask
	task t_mode(input logic [1:0] m, input logic [7:0] eo, et, ws);
		xfer(m, 1'b1);
		exp4(8'h01, 8'h00, eo, et);
		check(nst, 8'h07);
		check(ndo, 8'h0A);
		xfer(m, 1'b0);
		exp4(8'h00, 8'h01, eo, et);
		check(nst, ws);
		check(ndo, 8'h00);
		$display("mode %h done", m);
	endtask
	task t_none;
		xfer(2'h3, 1'b1);
		exp4(8'h00, 8'h00, 8'h00, 8'h00);
		check(ndo, 8'h00);
		$display("no mode done");
	endtask
	task t_reset;
		@(posedge clk_in);
		mode <= 2'h0;
		go <= 1'b1;
		@(posedge clk_in);
		go <= 1'b0;
		repeat (9) @(posedge clk_in);
		rst_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		#1;
		check({7'h00, hold_oe}, 8'h00);
		check({7'h00, hold}, 8'h01);
		check({7'h00, data_oe}, 8'h00);
		check({6'h00, rd_stb, wr_stb}, 8'h00);
		repeat (30) @(posedge clk_in);
		$display("reset done");
	endtask
	task end_of_test;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// ======
	// Run.
	initial forever #25 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 1000) begin
			n_fail++;
			end_of_test();
		end
	end
	initial begin
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		t_mode(2'h0, 8'h04, 8'h03, 8'h11);
		t_mode(2'h1, 8'h00, 8'h00, 8'h07);
		t_mode(2'h2, 8'h04, 8'h03, 8'h07);
		t_none();
		t_reset();
		end_of_test();
	end
endmodule
bind hbc_ctrl hbc_ctrl_monitor u_mon (.clk_in, .rst_in, .mode_in, .cs_n_in,
	.as_n_in, .hold_out, .hold_oe_out, .data_oe_out, .rd_stb_out, .wr_stb_out);
`default_nettype wire
